// *** inc/readout_pkg.sv ***
package readout_pkg;
	// Calibration store: nine ranges, two wire modes, two channels.
	localparam int NRANGE = 9;
	localparam int NCAL = 36;
	localparam int CAL_PER_CH = 18;
	localparam int CAL_PER_WIRE = 9;
	localparam int RAW_W = 26;
	localparam logic [3:0] RANGE_MAX = 4'h8;
	localparam logic [3:0] RANGE_TOP_AUTO = 4'h7;
	localparam logic [3:0] RANGE_MIN_2W_AUTO = 4'h3;
	localparam logic [27:0] FIX_FULL = 28'h07fffff;
	localparam logic [27:0] FIX_CLAMP = 28'h08ccccb;
	localparam logic [27:0] FIX_TENTH = 28'h00ccccc;
	localparam logic [15:0] CAL_GAIN_ONE = 16'h8000;
	localparam int GAIN_SHIFT = 15;
	localparam int FLT_EXP_BASE = 104;
	localparam int CLK_HZ = 25000000;
	localparam int TICK_US = 1000;
	localparam int TICK_CYC = CLK_HZ / 1000000 * TICK_US;
	localparam logic [15:0] DELAY_DFLT = 16'h000a;
	localparam logic [3:0] FILTER_10HZ = 4'h2;
	// Register map.
	localparam logic [11:0] A_CTRL = 12'h000;
	localparam logic [11:0] A_TRIG = 12'h004;
	localparam logic [7:0] PG_CH0 = 8'h01;
	localparam logic [7:0] PG_CH1 = 8'h02;
	localparam logic [3:0] PG_FCAL = 4'h1;
	localparam logic [3:0] PG_UCAL = 4'h2;
	localparam logic [3:0] O_CFG = 4'h0;
	localparam logic [3:0] O_DELAY = 4'h4;
	localparam logic [3:0] O_FILT = 4'h8;
	localparam logic [3:0] O_STAT = 4'hc;
	localparam int CTRL_CW_MODE = 0;
	localparam int CFG_AUTO = 0;
	localparam int CFG_RANGE_LSB = 4;
	localparam int CFG_MODE_LSB = 8;
	localparam int CFG_UCAL = 12;
	// Control word fields.
	localparam int CW_NO_AUTO = 0;
	localparam int CW_START = 1;
	localparam int CW_RANGE_LSB = 4;
	localparam int CW_MODE_LSB = 8;
	// Status word fields.
	localparam int ST_UNDER = 0;
	localparam int ST_OVER = 1;
	localparam int ST_EXT = 2;
	localparam int ST_ERR = 6;
	localparam int ST_SETTLED = 8;
	localparam int ST_INVALID = 9;
	localparam int ST_TXSTATE = 14;
	localparam int ST_TOGGLE = 15;
	localparam logic [15:0] ST_RESET = 16'h4200;
	// Range end values 10^r ohm as 24-bit mantissa and power of two.
	localparam logic [8:0][23:0] DEC_MANT = {24'hbebc20, 24'h989680,
		24'hf42400, 24'hc35000, 24'h9c4000, 24'hfa0000, 24'hc80000,
		24'ha00000, 24'h800000};
	localparam int DEC_EXP [9] = '{0, 3, 6, 9, 13, 16, 19, 23, 26};

	typedef enum logic [1:0] {
		MODE_4W_CONT = 2'h0,
		MODE_4W_SINGLE = 2'h1,
		MODE_2W_CONT = 2'h2,
		MODE_2W_SINGLE = 2'h3
	} meas_mode_t;

	typedef struct packed {
		logic auto_on;
		logic [3:0] range;
		meas_mode_t mode;
		logic user_cal;
		logic [15:0] delay;
		logic [3:0] filter;
	} chan_cfg_t;

	typedef struct packed {
		logic [15:0] status;
		logic [31:0] value;
		logic [7:0] selected_range_out;
		logic [31:0] scaled_value_out;
	} chan_pd_t;

	typedef struct packed {
		logic [11:0] paddr;
		logic psel;
		logic penable;
		logic pwrite;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} apb_rsp_t;

	typedef struct packed {
		logic req;
		logic chan;
		logic [3:0] range;
		logic two_wire;
		logic [3:0] filter;
	} meas_req_t;

	typedef struct packed {
		logic done;
		logic [RAW_W-1:0] raw;
		logic error;
	} meas_rsp_t;
endpackage : readout_pkg

// *** logic/resistance_readout.sv ***
`timescale 1ns/10ps
`default_nettype none
// How it works
// - One engine alternates between the two channels.
// - Wait per-channel settling delay before measuring.
// - Publish status, fixed value, range, scaled value.
// - Nine ranges, all starting at zero ohm.
// - Fixed value: 24 bits, full scale 007fffff.
// - Autorange keeps converting to ten percent over.
// - Extended flag in overspan; clamp 008ccccb above.
// - Autorange steps down below ten percent.
// - Device makes the range-independent float value.
// - Open channel settles in range seven.
// - Config registers steer autorange, range, wire mode.
// - Control word mode takes autorange, range, mode, start from control word.
// - Transmit state zero when valid; toggle each result.
// - Reset gives four-wire, register control, autorange.
// - Thirty-six factory and thirty-six user calibrations.
// - Two-wire autorange avoids lowest three ranges.
// - Lowest ranges in two-wire remain manually selectable.
// - Mode codes: 4W cont, 4W single, 2W cont, 2W single.
// - Filter defaults to ten hertz after reset.
module resistance_readout #(
	parameter int TICK_CYCLES = readout_pkg::TICK_CYC
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// APB register port
	input wire readout_pkg::apb_req_t apb_req,
	output var readout_pkg::apb_rsp_t apb_rsp,
	// Control words from the fieldbus side, one per channel
	input wire logic [1:0][15:0] ctl_word,
	// Input data to the fieldbus side, one set per channel
	output var readout_pkg::chan_pd_t [1:0] pd_out,
	// Measurement engine
	output var readout_pkg::meas_req_t meas_req,
	input wire readout_pkg::meas_rsp_t meas_rsp
);
	import readout_pkg::*;

	if (TICK_CYCLES < 1) begin : g_bad_tick
		$error("TICK_CYCLES must be at least 1");
	end

	typedef enum logic [1:0] {PH_IDLE, PH_SETTLE, PH_MEASURE, PH_PUBLISH} phase_t;

	typedef struct packed {
		apb_rsp_t apb;
		logic cw_mode;
		chan_cfg_t [1:0] cfg;
		logic [1:0][3:0] rng;
		logic [1:0] pend;
		logic [1:0] start_q;
		logic [NCAL-1:0][31:0] fcal;
		logic [NCAL-1:0][31:0] ucal;
		phase_t ph;
		logic ch;
		logic [15:0] dly_cnt;
		logic [31:0] tick_cnt;
		meas_req_t meas;
		logic [RAW_W-1:0] raw;
		logic err;
		chan_pd_t [1:0] pd;
	} state_t;

	localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);

	state_t r;
	state_t n;

	// In control word mode the word replaces the autorange, range and mode fields.
	function automatic chan_cfg_t eff_cfg(input logic cw_mode,
		input chan_cfg_t c, input logic [15:0] cw);
		chan_cfg_t e;
		e = c;
		if (cw_mode) begin
			e.auto_on = !cw[CW_NO_AUTO];
			e.range = cw[CW_RANGE_LSB +: 4];
			e.mode = meas_mode_t'(cw[CW_MODE_LSB +: 2]);
		end
		return e;
	endfunction : eff_cfg

	function automatic logic [3:0] pick_range(input chan_cfg_t e,
		input logic [3:0] rng);
		logic [3:0] v;
		v = e.auto_on ? rng : e.range;
		if (v > RANGE_MAX)
			v = RANGE_MAX;
		// Manual selection may use the low ranges in two-wire mode.
		if (e.auto_on && e.mode[1] && v < RANGE_MIN_2W_AUTO)
			v = RANGE_MIN_2W_AUTO;
		return v;
	endfunction : pick_range

	function automatic logic addr_hit(input logic [11:0] a);
		logic ok;
		ok = (a == A_CTRL) || (a == A_TRIG) || (a[11:4] == PG_CH0) ||
			(a[11:4] == PG_CH1);
		ok = ok || ((a[11:8] == PG_FCAL || a[11:8] == PG_UCAL) &&
			int'(a[7:2]) < NCAL);
		return ok && (a[1:0] == 2'b00);
	endfunction : addr_hit

	// Scaled value: fixed value times 10^range / 2^23 as a single float.
	function automatic logic [31:0] to_float(input logic [23:0] v,
		input logic [3:0] rg);
		logic [4:0] p;
		logic [23:0] nv;
		logic [47:0] pr;
		logic [22:0] man;
		int e;
		p = 5'h00;
		for (int i = 0; i < 24; i++) begin
			if (v[i])
				p = 5'(i);
		end
		nv = v << (5'h17 - p);
		pr = 48'(nv) * 48'(DEC_MANT[rg]);
		if (pr[47]) begin
			man = pr[46:24];
			e = FLT_EXP_BASE + 1 + int'(p) + DEC_EXP[rg];
		end else begin
			man = pr[45:23];
			e = FLT_EXP_BASE + int'(p) + DEC_EXP[rg];
		end
		if (v == 24'h000000)
			return 32'h00000000;
		return {1'b0, e[7:0], man};
	endfunction : to_float

	chan_cfg_t [1:0] eff;
	logic [1:0] cont;
	logic [1:0] elig;
	for (genvar g = 0; g < 2; g++) begin : g_chan
		assign eff[g] = eff_cfg(r.cw_mode, r.cfg[g], ctl_word[g]);
		assign cont[g] = !eff[g].mode[0];
		assign elig[g] = cont[g] || r.pend[g];
	end

	// Both triggered single shots start with the first channel.
	logic nxt_ch;
	assign nxt_ch = (r.pend == 2'b11 && cont == 2'b00) ? 1'b0 :
		(elig[!r.ch] ? !r.ch : r.ch);

	logic tick;
	assign tick = (r.tick_cnt == TICK_LAST);

	// Result formatting for the channel just measured.
	chan_cfg_t cur;
	logic two;
	logic [5:0] cal_idx;
	logic [31:0] cal_w;
	logic [41:0] prod;
	logic [28:0] corr;
	logic [27:0] mag;
	logic [27:0] fix;
	logic over_lim;
	logic ext;
	logic up;
	logic down;
	logic [3:0] floor_rg;
	logic [3:0] nxt_rng;
	logic invalid;
	assign cur = eff[r.ch];
	assign two = r.meas.two_wire;
	assign cal_idx = 6'(int'(r.ch) * CAL_PER_CH + int'(two) * CAL_PER_WIRE +
		int'(r.meas.range));
	assign cal_w = cur.user_cal ? r.ucal[cal_idx] : r.fcal[cal_idx];
	assign prod = 42'(r.raw) * 42'(cal_w[31:16]);
	assign corr = {2'b00, prod[41:GAIN_SHIFT]} +
		{{13{cal_w[15]}}, cal_w[15:0]};
	assign mag = corr[28] ? 28'h0000000 : corr[27:0];
	assign over_lim = cur.auto_on ? (mag > FIX_CLAMP) : (mag > FIX_FULL);
	assign fix = over_lim ? (cur.auto_on ? FIX_CLAMP : FIX_FULL) : mag;
	assign ext = cur.auto_on && !over_lim && fix >= FIX_FULL;
	assign floor_rg = two ? RANGE_MIN_2W_AUTO : 4'h0;
	// The top autorange step is range seven, where an open input rests.
	assign up = cur.auto_on && over_lim && r.meas.range < RANGE_TOP_AUTO;
	assign down = cur.auto_on && !over_lim && fix < FIX_TENTH &&
		r.meas.range > floor_rg;
	assign nxt_rng = up ? r.meas.range + 4'h1 :
		(down ? r.meas.range - 4'h1 : r.meas.range);
	assign invalid = r.err || up || down;

	always_comb begin
		logic wc;
		logic [11:0] a;
		logic [31:0] d;
		wc = 1'b0;
		a = apb_req.paddr;
		d = apb_req.pwdata;
		n = r;
		n.tick_cnt = tick ? 32'h00000000 : r.tick_cnt + 32'h00000001;

		unique case (r.ph)
			PH_IDLE: begin
				if (elig[nxt_ch]) begin
					n.ch = nxt_ch;
					n.pend[nxt_ch] = 1'b0;
					n.dly_cnt = eff[nxt_ch].delay;
					n.ph = PH_SETTLE;
				end
			end
			PH_SETTLE: begin
				if (r.dly_cnt == 16'h0000) begin
					n.meas.req = 1'b1;
					n.meas.chan = r.ch;
					n.meas.range = pick_range(cur, r.rng[r.ch]);
					n.meas.two_wire = cur.mode[1];
					n.meas.filter = cur.filter;
					n.ph = PH_MEASURE;
				end else if (tick) begin
					n.dly_cnt = r.dly_cnt - 16'h0001;
				end
			end
			PH_MEASURE: begin
				if (meas_rsp.done) begin
					n.meas.req = 1'b0;
					n.raw = meas_rsp.raw;
					n.err = meas_rsp.error;
					n.ph = PH_PUBLISH;
				end
			end
			PH_PUBLISH: begin
				// All four items of the channel are replaced in one edge.
				n.pd[r.ch].value = {8'h00, fix[23:0]};
				n.pd[r.ch].selected_range_out = {4'h0, r.meas.range};
				n.pd[r.ch].scaled_value_out = to_float(fix[23:0],
					r.meas.range);
				n.pd[r.ch].status = 16'h0000;
				n.pd[r.ch].status[ST_UNDER] = corr[28];
				n.pd[r.ch].status[ST_OVER] = over_lim;
				n.pd[r.ch].status[ST_EXT] = ext;
				n.pd[r.ch].status[ST_ERR] = r.err || over_lim;
				n.pd[r.ch].status[ST_INVALID] = invalid;
				n.pd[r.ch].status[ST_SETTLED] = !invalid &&
					r.pd[r.ch].selected_range_out[3:0] == r.meas.range;
				n.pd[r.ch].status[ST_TXSTATE] = 1'b0;
				n.pd[r.ch].status[ST_TOGGLE] =
					!r.pd[r.ch].status[ST_TOGGLE];
				n.rng[r.ch] = cur.auto_on ? nxt_rng : r.meas.range;
				n.ph = PH_IDLE;
			end
		endcase

		// A trigger that lands with the scheduler's clear still counts.
		for (int c = 0; c < 2; c++) begin
			n.start_q[c] = ctl_word[c][CW_START];
			if (r.cw_mode && ctl_word[c][CW_START] && !r.start_q[c])
				n.pend[c] = 1'b1;
		end

		// APB: one wait state, so pready rises in the second access cycle.
		n.apb.pready = 1'b0;
		n.apb.pslverr = 1'b0;
		if (apb_req.psel && apb_req.penable && !r.apb.pready) begin
			n.apb.pready = 1'b1;
			n.apb.pslverr = !addr_hit(a);
			n.apb.prdata = 32'h00000000;
			wc = (a[11:4] == PG_CH1);
			if (a == A_CTRL) begin
				n.apb.prdata[CTRL_CW_MODE] = r.cw_mode;
			end else if (a[11:4] == PG_CH0 || a[11:4] == PG_CH1) begin
				if (a[3:0] == O_CFG) begin
					n.apb.prdata[CFG_AUTO] = r.cfg[wc].auto_on;
					n.apb.prdata[CFG_RANGE_LSB +: 4] = r.cfg[wc].range;
					n.apb.prdata[CFG_MODE_LSB +: 2] = r.cfg[wc].mode;
					n.apb.prdata[CFG_UCAL] = r.cfg[wc].user_cal;
				end else if (a[3:0] == O_DELAY) begin
					n.apb.prdata[15:0] = r.cfg[wc].delay;
				end else if (a[3:0] == O_FILT) begin
					n.apb.prdata[3:0] = r.cfg[wc].filter;
				end else if (a[3:0] == O_STAT) begin
					n.apb.prdata = {12'h000, r.rng[wc], r.pd[wc].status};
				end
			end else if (addr_hit(a) && a[11:8] == PG_FCAL) begin
				n.apb.prdata = r.fcal[a[7:2]];
			end else if (addr_hit(a) && a[11:8] == PG_UCAL) begin
				n.apb.prdata = r.ucal[a[7:2]];
			end
		end

		// Writes take effect at the edge that sees pready high.
		if (apb_req.psel && apb_req.penable && r.apb.pready &&
			apb_req.pwrite && addr_hit(a)) begin
			wc = (a[11:4] == PG_CH1);
			if (a == A_CTRL) begin
				n.cw_mode = d[CTRL_CW_MODE];
			end else if (a == A_TRIG) begin
				if (!r.cw_mode)
					n.pend = n.pend | d[1:0];
			end else if (a[11:4] == PG_CH0 || a[11:4] == PG_CH1) begin
				if (a[3:0] == O_CFG) begin
					n.cfg[wc].auto_on = d[CFG_AUTO];
					n.cfg[wc].range = d[CFG_RANGE_LSB +: 4];
					n.cfg[wc].mode = meas_mode_t'(d[CFG_MODE_LSB +: 2]);
					n.cfg[wc].user_cal = d[CFG_UCAL];
					// Writing a single-shot mode also requests one reading.
					if (!r.cw_mode && d[CFG_MODE_LSB])
						n.pend[wc] = 1'b1;
				end else if (a[3:0] == O_DELAY) begin
					n.cfg[wc].delay = d[15:0];
				end else if (a[3:0] == O_FILT) begin
					n.cfg[wc].filter = d[3:0];
				end
			end else if (a[11:8] == PG_FCAL) begin
				n.fcal[a[7:2]] = d;
			end else begin
				n.ucal[a[7:2]] = d;
			end
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			r <= '0;
			for (int c = 0; c < 2; c++) begin
				r.cfg[c].auto_on <= 1'b1;
				r.cfg[c].mode <= MODE_4W_CONT;
				r.cfg[c].delay <= DELAY_DFLT;
				r.cfg[c].filter <= FILTER_10HZ;
				r.rng[c] <= RANGE_TOP_AUTO;
				r.pd[c].status <= ST_RESET;
			end
			for (int i = 0; i < NCAL; i++) begin
				r.fcal[i] <= {CAL_GAIN_ONE, 16'h0000};
				r.ucal[i] <= {CAL_GAIN_ONE, 16'h0000};
			end
		end else begin
			r <= n;
		end
	end

	assign apb_rsp = r.apb;
	assign pd_out = r.pd;
	assign meas_req = r.meas;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!resetn);

	alternate_chan_a: assert property (
		(r.ph == PH_IDLE && cont == 2'b11) |=> r.ch != $past(r.ch))
		else $error("continuous channels did not alternate");

	settle_hold_a: assert property (
		(r.ph == PH_SETTLE && r.dly_cnt != 16'h0000) |=> !r.meas.req)
		else $error("measurement started before settling ended");

	clamp_value_a: assert property (
		(r.ph == PH_PUBLISH && over_lim && cur.auto_on) |=>
		r.pd[$past(r.ch)].value == 32'(FIX_CLAMP) &&
		r.pd[$past(r.ch)].status[ST_OVER] &&
		!r.pd[$past(r.ch)].status[ST_EXT])
		else $error("over-limit value not clamped");

	ext_span_a: assert property (
		(r.ph == PH_PUBLISH && cur.auto_on && mag >= FIX_FULL &&
		mag <= FIX_CLAMP) |=> r.pd[$past(r.ch)].status[ST_EXT] &&
		!r.pd[$past(r.ch)].status[ST_OVER])
		else $error("extended span flags wrong");

	range_down_a: assert property (
		(r.ph == PH_PUBLISH && down) |=>
		r.rng[$past(r.ch)] == $past(r.meas.range) - 4'h1)
		else $error("autorange did not step down");

	range_up_a: assert property (
		(r.ph == PH_PUBLISH && up) |=>
		r.rng[$past(r.ch)] == $past(r.meas.range) + 4'h1)
		else $error("autorange did not step up");

	two_wire_floor_a: assert property (
		$rose(r.meas.req) && r.meas.two_wire && eff[r.meas.chan].auto_on
		|-> r.meas.range >= RANGE_MIN_2W_AUTO)
		else $error("two-wire autorange used a low range");

	result_toggle_a: assert property (
		r.ph == PH_PUBLISH |=> r.pd[$past(r.ch)].status[ST_TOGGLE] !=
		$past(r.pd[r.ch].status[ST_TOGGLE]) &&
		!r.pd[$past(r.ch)].status[ST_TXSTATE])
		else $error("toggle or transmit state wrong on new result");

	coherent_out_a: assert property (
		$changed(r.pd) |-> $past(r.ph) == PH_PUBLISH)
		else $error("outputs changed outside a publication");

	auto_top_a: assert property (
		$rose(r.meas.req) && eff[r.meas.chan].auto_on |->
		r.meas.range <= RANGE_TOP_AUTO)
		else $error("autorange went above range seven");

	apb_wait_a: assert property (
		(apb_req.psel && apb_req.penable && !r.apb.pready) |=>
		r.apb.pready ##1 !r.apb.pready)
		else $error("APB answer not after one wait state");
endmodule : resistance_readout
`default_nettype wire

// *** test/engine_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// Behavioural measurement engine that answers each request after lat + 1 cycles.
module engine_model (
	// Clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// Request and answer
	input wire readout_pkg::meas_req_t meas_req,
	output var readout_pkg::meas_rsp_t meas_rsp,
	// Bench controls
	input wire logic [1:0][25:0] raw_val,
	input wire logic [7:0] lat
);
	import readout_pkg::*;
	logic [7:0] cnt_r;
	// Between answers the raw lines flip, so a stale reading is never valid.
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			cnt_r <= 8'h00;
			meas_rsp <= '0;
		end else begin
			meas_rsp.done <= 1'b0;
			meas_rsp.raw <= ~meas_rsp.raw;
			if (meas_req.req && !meas_rsp.done) begin
				if (cnt_r >= lat) begin
					meas_rsp.done <= 1'b1;
					meas_rsp.raw <= raw_val[meas_req.chan];
					cnt_r <= 8'h00;
				end else begin
					cnt_r <= cnt_r + 8'h01;
				end
			end
		end
	end
endmodule : engine_model
`default_nettype wire

// *** test/dual_channel_resistance_readout_ctrl_test.sv ***
`timescale 1ns/10ps
`default_nettype none
module dual_channel_resistance_readout_ctrl_test;
	import readout_pkg::*;
	logic mclk = 1'b0;
	logic resetn = 1'b0;
	apb_req_t apb_req = '0;
	apb_rsp_t apb_rsp;
	logic [1:0][15:0] ctl_word = {16'h0151, 16'h0151};
	chan_pd_t [1:0] pd_out;
	meas_req_t meas_req;
	meas_rsp_t meas_rsp;
	logic [1:0][25:0] raw_val = '0;
	logic [7:0] lat = 8'h02;
	int bad_count = 0;
	int compares = 0;
	int cyc = 0;
	int first_req = 0;
	int seed = 32'h534209df;
	int k;
	logic chk_alt = 1'b1;
	logic ok = 1'b1;
	logic low_raw = 1'b0;
	logic [1:0] man = 2'b00;
	logic [1:0] tg = 2'b00;
	logic [1:0] lastc = 2'b10;
	logic [1:0][3:0] exp_rng = {4'h7, 4'h7};
	logic mc, ov, ex, sc, sw, ev, inv;
	logic [3:0] mr, sr;
	logic [25:0] mx, mv;
	logic [31:0] p, rdv;
	logic [25:0] cor [5] = '{26'h7fffff, 26'h8ccccb, 26'h8ccccc, 26'hccccb, 26'h0};

	always #20 mclk = ~mclk;

	resistance_readout #(.TICK_CYCLES(4)) resistance_readout_i (.mclk(mclk),
		.resetn(resetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
		.ctl_word(ctl_word), .pd_out(pd_out), .meas_req(meas_req),
		.meas_rsp(meas_rsp));
	engine_model engine_model_i (.mclk(mclk), .resetn(resetn),
		.meas_req(meas_req), .meas_rsp(meas_rsp), .raw_val(raw_val), .lat(lat));

	task end_sim;
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : end_sim

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	function automatic logic [25:0] fix(input logic [25:0] x, input logic m,
		output logic o, output logic e);
		o = 1'b0;
		e = 1'b0;
		if (m) begin
			o = x > FIX_FULL[25:0];
			return o ? FIX_FULL[25:0] : x;
		end
		if (x > FIX_CLAMP[25:0]) begin
			o = 1'b1;
			return FIX_CLAMP[25:0];
		end
		e = x >= FIX_FULL[25:0];
		return x;
	endfunction : fix

	function automatic logic [3:0] nxt(input logic [3:0] r, input logic [25:0] x,
		input logic m, input logic w);
		if (m) return r;
		if (x > FIX_CLAMP[25:0]) return (r < 4'h7) ? r + 4'h1 : r;
		if (x < FIX_TENTH[25:0]) return (r > (w ? 4'h3 : 4'h0)) ? r - 4'h1 : r;
		return r;
	endfunction : nxt

	function automatic logic [25:0] rnd();
		logic [31:0] q;
		q = $random(seed);
		if (q[2:0] == 3'h0) return cor[q[5:3] % 5];
		return low_raw ? {6'h0, q[19:0]} : 26'(q % 32'ha00000);
	endfunction : rnd

	task apb(input logic [11:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] rd, output logic e);
		int n;
		n = 0;
		@(posedge mclk);
		apb_req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w,
			pwdata: d};
		@(posedge mclk);
		apb_req.penable <= 1'b1;
		do begin
			@(posedge mclk);
			n++;
		end while (apb_rsp.pready !== 1'b1 && n < 50);
		rd = apb_rsp.prdata;
		e = apb_rsp.pslverr;
		apb_req.psel <= 1'b0;
		apb_req.penable <= 1'b0;
		if (n >= 50) begin
			bad_count++;
			end_sim;
		end
	endtask : apb

	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(a, 1'b1, d, rdv, ev);
	endtask : wr

	task rd_chk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
		apb(a, 1'b0, 32'h0, rdv, ev);
		chk(rdv & m, x);
	endtask : rd_chk

	// A loop rather than recursion; the task is automatic, so each call gets its own frame.
	task automatic wait_done(input int t);
		int n;
		repeat (t) begin
			n = 0;
			do begin
				@(posedge mclk);
				n++;
			end while (meas_rsp.done !== 1'b1 && n < 3000);
			sc = meas_req.chan;
			sr = meas_req.range;
			sw = meas_req.two_wire;
			if (n >= 3000) begin
				bad_count++;
				end_sim;
			end
		end
	endtask : wait_done

	task count_done(input int n);
		k = 0;
		repeat (n) begin
			@(posedge mclk);
			if (meas_rsp.done === 1'b1) k++;
		end
	endtask : count_done

	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (resetn && meas_req.req === 1'b1 && first_req == 0) first_req <= cyc;
		if (cyc == 60000) begin
			bad_count++;
			end_sim;
		end
	end

	// Every published result is predicted from the raw reading it came from.
	always @(posedge mclk) begin
		if (resetn === 1'b1 && meas_rsp.done === 1'b1) begin
			mc = meas_req.chan;
			mr = meas_req.range;
			mx = meas_rsp.raw;
			p = $random(seed);
			lat <= {4'h0, p[3:0]};
			raw_val <= {rnd(), rnd()};
			if (chk_alt && !lastc[1]) chk(32'(mc), 32'(!lastc[0]));
			lastc = {1'b0, mc};
			if (ok) chk(32'(mr), 32'(exp_rng[mc]));
			mv = fix(mx, man[mc], ov, ex);
			exp_rng[mc] = nxt(mr, mx, man[mc], meas_req.two_wire);
			inv = exp_rng[mc] != mr;
			chk(32'(meas_req.filter), 32'(FILTER_10HZ));
			tg[mc] = !tg[mc];
			repeat (2) @(posedge mclk);
			#1;
			if (ok) begin
				chk(pd_out[mc].value, 32'(mv));
				chk(32'(pd_out[mc].selected_range_out), 32'(mr));
				chk(32'(pd_out[mc].status & 16'hc006),
					32'({tg[mc], 12'h0, ex, ov, 1'b0}));
				chk(32'(pd_out[mc].status & 16'hc246),
					32'({tg[mc], 5'h0, inv, 2'b0, ov, 3'b0, ex, ov, 1'b0}));
				if (mv == 26'h0) chk(pd_out[mc].scaled_value_out, 32'h0);
				if (mv == FIX_FULL[25:0] && mr == 4'h0)
					chk(pd_out[mc].scaled_value_out, 32'h3f7ffffe);
			end
		end
	end

	initial begin
		raw_val = {rnd(), rnd()};
		repeat (10) @(posedge mclk);
		#1;
		chk(32'(pd_out[0].status), 32'h4200);
		chk(32'(pd_out[1].status), 32'h4200);
		chk(32'(meas_req), 32'h0);
		repeat (10) @(posedge mclk);
		resetn <= 1'b1;
		rd_chk(12'h01c, 32'hffffffff, 32'h00074200);
		rd_chk(12'h010, 32'h00000301, 32'h00000001);
		rd_chk(12'h018, 32'h0000000f, 32'h00000002);
		rd_chk(12'h024, 32'h0000ffff, 32'h0000000a);
		apb(12'h008, 1'b0, 32'h0, rdv, ev);
		chk({ev, rdv[30:0]}, 32'h80000000);
		wr(12'h014, 32'h0);
		wr(12'h024, 32'h0);
		wait_done(40);
		chk(32'(first_req >= 55 && first_req <= 70), 32'h1);
		$display("test auto four wire done");
		ok = 1'b0;
		low_raw = 1'b1;
		wr(12'h010, 32'h201);
		wr(12'h020, 32'h201);
		wait_done(6);
		ok = 1'b1;
		wait_done(20);
		chk(32'(sw), 32'h1);
		$display("test auto two wire done");
		ok = 1'b0;
		low_raw = 1'b0;
		man[0] = 1'b1;
		wr(12'h010, 32'h200);
		wait_done(6);
		ok = 1'b1;
		wait_done(16);
		$display("test manual low range done");
		ok = 1'b0;
		chk_alt = 1'b0;
		man = 2'b00;
		wr(12'h010, 32'h101);
		wr(12'h020, 32'h301);
		count_done(300);
		count_done(300);
		chk(32'(k), 32'h0);
		wr(12'h004, 32'h3);
		wait_done(1);
		chk(32'({sc, sw}), 32'h0);
		wait_done(1);
		chk(32'({sc, sw}), 32'h3);
		$display("test single shot done");
		man = 2'b11;
		wr(12'h000, 32'h1);
		count_done(300);
		wr(12'h004, 32'h3);
		count_done(300);
		chk(32'(k), 32'h0);
		exp_rng = {4'h5, 4'h5};
		ok = 1'b1;
		ctl_word[0] <= 16'h0153;
		wait_done(1);
		chk(32'(sc), 32'h0);
		ctl_word[1] <= 16'h0353;
		wait_done(1);
		chk(32'({sc, sw}), 32'h3);
		repeat (4) @(posedge mclk);
		$display("test control word done");
		end_sim;
	end
endmodule : dual_channel_resistance_readout_ctrl_test
`default_nettype wire
